/* File: qsm_fifo_mem.sv */
`timescale 1ns/1ps
module qsm_fifo_mem
  import qsm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  qsm_mem_if.mem port
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] word;
    logic [7:0] rdata;
  } qsm_mem_s;

  qsm_mem_s cur, nxt;

  always_comb
  begin
    nxt = cur;
    if (port.we)
      nxt.word[port.waddr] = port.wdata;
    // Write-first so a byte pushed into an empty FIFO is seen next cycle
    if (port.we && port.waddr == port.raddr)
      nxt.rdata = port.wdata;
    else
      nxt.rdata = cur.word[port.raddr];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cur <= '0;
    else
      cur <= nxt;
  end

  assign port.rdata = cur.rdata;
endmodule

/* File: qsm_flash.sv */
`timescale 1ns/1ps
module qsm_flash (
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso
);
  logic [7:0] sh_out = 8'h00;
  logic [7:0] sh_in = 8'h00;
  logic [7:0] cur = 8'h00;
  logic [7:0] pat = 8'h96;
  int nbit = 0;
  logic [7:0] got[$];
  logic [7:0] sent[$];
  initial spi_miso = 1'b0;
  // First bit must stand before the first rising clock
  always @(negedge spi_cs_n)
  begin
    nbit = 0;
    cur = pat;
    sh_out = pat;
    spi_miso = pat[7];
  end
  always @(posedge spi_sclk)
    if (!spi_cs_n)
    begin
      sh_in = {sh_in[6:0], spi_mosi};
      nbit++;
      if (nbit % 8 == 0)
      begin
        got.push_back(sh_in);
        sent.push_back(cur);
        pat = pat * 8'h05 + 8'h03;
      end
    end
  // Mode 0: next bit goes out on the falling clock
  always @(negedge spi_sclk)
    if (!spi_cs_n)
    begin
      cur = (nbit % 8 == 0) ? pat : cur;
      sh_out = (nbit % 8 == 0) ? pat : sh_out << 1;
      spi_miso = sh_out[7];
    end
  // Released line shows a changed level, never a stale one
  always @(posedge spi_cs_n) spi_miso = ~spi_miso;
endmodule

/* File: qsm_mem_if.sv */
`timescale 1ns/1ps
interface qsm_mem_if;
  logic we;
  logic [qsm_pkg::PTR_W-1:0] waddr;
  logic [qsm_pkg::PTR_W-1:0] raddr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport user (output we, output waddr, output raddr, output wdata, input rdata);
  modport mem (input we, input waddr, input raddr, input wdata, output rdata);
endinterface

/* File: qsm_pkg.sv */
package qsm_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_PIN = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_CFG = 8'h20;
  localparam logic [7:0] OFF_TRIG = 8'h24;
  localparam logic [7:0] OFF_DATA = 8'h28;
  localparam int CMD_LAUNCH = 0;
  localparam int CMD_HALT = 1;
  localparam int CMD_FLUSH = 2;
  localparam int PIN_WP_VAL = 0;
  localparam int PIN_WP_EN = 1;
  localparam int PIN_HOLD_VAL = 2;
  localparam int PIN_HOLD_EN = 3;
  localparam int ST_TX_REQ = 10;
  localparam int ST_TX_STALL = 11;
  localparam int ST_RX_REQ = 14;
  localparam int ST_RX_STALL = 15;
  localparam int CFG_CLOSE = 0;
  localparam int CFG_DESC_EN = 1;
  localparam int CFG_TX_EN = 2;
  localparam int CFG_RX_EN = 3;
  localparam int CFG_PTR_LO = 4;
  localparam int CFG_LEN_LO = 16;
  localparam int TRIG_RX_LO = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [3:0] PIN_RST = 4'h0;
  localparam logic CS_IDLE = 1'b1;
  localparam logic [7:0] TX_IDLE_BYTE = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_MHZ = 20;
  localparam int SCK_HALF_NS = 100;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] SCK_HALF_LAST = 2'(SCK_HALF_CYC - 1);
  typedef enum logic [1:0] {QSM_IDLE, QSM_BYTE, QSM_SHIFT} qsm_phase_e;
endpackage

/* File: qsm_quad_serial_master.sv */
`timescale 1ns/1ps
module qsm_quad_serial_master
  import qsm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic spi_hold,
  output logic spi_hold_oe_n,
  output logic spi_wp,
  output logic spi_wp_oe_n
);
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] pin;
    logic close_en;
    logic desc_en;
    logic tx_en;
    logic rx_en;
    logic [3:0] desc_ptr;
    logic [15:0] xfer_len;
    logic [3:0] tx_trig;
    logic [3:0] rx_trig;
    logic rx_stall;
    logic rx_req;
    logic tx_stall;
    logic tx_req;
    logic halt_pend;
    qsm_phase_e state;
    logic [1:0] div;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] rxsh;
    logic rx_pend;
    logic [15:0] done_cnt;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [PTR_W-1:0] tx_wr;
    logic [PTR_W-1:0] tx_rd;
    logic [CNT_W-1:0] tx_cnt;
    logic [PTR_W-1:0] rx_wr;
    logic [PTR_W-1:0] rx_rd;
    logic [CNT_W-1:0] rx_cnt;
    logic miso_s1;
    logic miso_s2;
  } qsm_state_s;

  qsm_state_s cur, nxt;
  qsm_mem_if tx_if ();
  qsm_mem_if rx_if ();
  logic wr_do, launch, halt_cmd, flush, tx_push, tx_pop, rx_push, rx_pop;
  logic clr_rx_stall, clr_rx_req, clr_tx_stall, clr_tx_req;
  logic set_rx_stall, set_tx_stall;
  logic [31:0] status_word;

  function automatic logic fifo_full(input logic [CNT_W-1:0] cnt);
    fifo_full = (cnt == CNT_W'(FIFO_DEPTH));
  endfunction

  function automatic logic [CNT_W-1:0] fifo_next(input logic [CNT_W-1:0] cnt,
                                                 input logic push, input logic pop);
    fifo_next = cnt + CNT_W'(push) - CNT_W'(pop);
  endfunction

  // Field 27:24 is only meaningful with description buffers on
  assign status_word = {4'h0, (cur.desc_en ? cur.desc_ptr : 4'h0), 7'h00,
                        (cur.state != QSM_IDLE),
                        cur.rx_stall, cur.rx_req, (cur.rx_cnt == '0),
                        fifo_full(cur.rx_cnt), cur.tx_stall, cur.tx_req,
                        (cur.tx_cnt == '0), fifo_full(cur.tx_cnt), 8'h00};

  always_comb
  begin
    nxt = cur;
    wr_do = cur.aw_got && cur.w_got && !cur.bvalid;
    launch = 1'b0;
    halt_cmd = 1'b0;
    flush = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    clr_rx_stall = 1'b0;
    clr_rx_req = 1'b0;
    clr_tx_stall = 1'b0;
    clr_tx_req = 1'b0;
    set_rx_stall = 1'b0;
    set_tx_stall = 1'b0;
    nxt.miso_s1 = spi_miso;
    nxt.miso_s2 = cur.miso_s1;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt.aw_got = 1'b1;
      nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt.w_got = 1'b1;
      nxt.w_data = s_axi_wdata;
      nxt.w_strb = s_axi_wstrb;
    end
    if (cur.bvalid && s_axi_bready)
      nxt.bvalid = 1'b0;
    if (cur.rvalid && s_axi_rready)
      nxt.rvalid = 1'b0;
    if (wr_do)
    begin
      nxt.aw_got = 1'b0;
      nxt.w_got = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = RESP_OKAY;
      case (cur.aw_addr)
        OFF_CMD:
          if (cur.w_strb[0])
          begin
            flush = cur.w_data[CMD_FLUSH];
            halt_cmd = cur.w_data[CMD_HALT];
            // Halt wins if software breaks the exclusivity
            launch = cur.w_data[CMD_LAUNCH] && !cur.w_data[CMD_HALT];
          end
        OFF_PIN:
          if (cur.w_strb[0])
            nxt.pin = cur.w_data[3:0];
        OFF_STAT:
          if (cur.w_strb[1])
          begin
            clr_rx_stall = cur.w_data[ST_RX_STALL];
            clr_rx_req = cur.w_data[ST_RX_REQ];
            clr_tx_stall = cur.w_data[ST_TX_STALL];
            clr_tx_req = cur.w_data[ST_TX_REQ];
          end
        OFF_CFG:
        begin
          if (cur.w_strb[0])
          begin
            nxt.close_en = cur.w_data[CFG_CLOSE];
            nxt.desc_en = cur.w_data[CFG_DESC_EN];
            nxt.tx_en = cur.w_data[CFG_TX_EN];
            nxt.rx_en = cur.w_data[CFG_RX_EN];
            nxt.desc_ptr = cur.w_data[CFG_PTR_LO+:4];
          end
          if (cur.w_strb[2])
            nxt.xfer_len[7:0] = cur.w_data[CFG_LEN_LO+:8];
          if (cur.w_strb[3])
            nxt.xfer_len[15:8] = cur.w_data[CFG_LEN_LO+8+:8];
        end
        OFF_TRIG:
        begin
          if (cur.w_strb[0])
            nxt.tx_trig = cur.w_data[3:0];
          if (cur.w_strb[1])
            nxt.rx_trig = cur.w_data[TRIG_RX_LO+:4];
        end
        OFF_DATA:
          tx_push = cur.w_strb[0] && !fifo_full(cur.tx_cnt);
        default:
          nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt.rvalid = 1'b1;
      nxt.rresp = RESP_OKAY;
      nxt.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        OFF_CMD:
          nxt.rdata = 32'h0000_0000;
        OFF_PIN:
          nxt.rdata = {28'h000_0000, cur.pin};
        OFF_STAT:
          nxt.rdata = status_word;
        OFF_CFG:
          nxt.rdata = {cur.xfer_len, 8'h00, cur.desc_ptr, cur.rx_en, cur.tx_en,
                       cur.desc_en, cur.close_en};
        OFF_TRIG:
          nxt.rdata = {20'h0_0000, cur.rx_trig, 4'h0, cur.tx_trig};
        OFF_DATA:
          if (cur.rx_cnt != '0)
          begin
            nxt.rdata = {24'h00_0000, rx_if.rdata};
            rx_pop = 1'b1;
          end
        default:
          nxt.rresp = RESP_SLVERR;
      endcase
    end
    if (halt_cmd && cur.state != QSM_IDLE)
      nxt.halt_pend = 1'b1;
    case (cur.state)
      QSM_IDLE:
        if (halt_cmd)
        begin
          nxt.cs_n = CS_IDLE;
          nxt.halt_pend = 1'b0;
        end
        else if (launch)
        begin
          nxt.state = QSM_BYTE;
          nxt.done_cnt = 16'h0000;
        end
      QSM_BYTE:
        if (cur.rx_pend)
        begin
          // Clock stays parked until there is room for the byte
          if (fifo_full(cur.rx_cnt))
          begin
            nxt.rx_stall = 1'b1;
            set_rx_stall = 1'b1;
          end
          else
          begin
            rx_push = 1'b1;
            nxt.rx_pend = 1'b0;
          end
        end
        else if (cur.halt_pend || (cur.xfer_len != '0 && cur.done_cnt == cur.xfer_len))
        begin
          // Without close or a halt the slave stays selected for a follow-on launch
          if (cur.halt_pend || halt_cmd || cur.close_en)
            nxt.cs_n = CS_IDLE;
          nxt.halt_pend = 1'b0;
          nxt.state = QSM_IDLE;
        end
        else if (cur.tx_en && cur.tx_cnt == '0)
        begin
          nxt.tx_stall = 1'b1;
          set_tx_stall = 1'b1;
        end
        else
        begin
          nxt.shreg = cur.tx_en ? tx_if.rdata : TX_IDLE_BYTE;
          nxt.mosi = nxt.shreg[7];
          tx_pop = cur.tx_en;
          nxt.cs_n = 1'b0;
          nxt.bit_cnt = 3'h0;
          nxt.div = 2'h0;
          nxt.state = QSM_SHIFT;
        end
      QSM_SHIFT:
        if (cur.div == SCK_HALF_LAST)
        begin
          nxt.div = 2'h0;
          nxt.sclk = !cur.sclk;
          // Sampled on the fall: the two-flop lag hides the bit until then
          if (cur.sclk)
          begin
            nxt.rxsh = {cur.rxsh[6:0], cur.miso_s2};
            nxt.shreg = {cur.shreg[6:0], 1'b0};
            nxt.mosi = cur.shreg[6];
            nxt.bit_cnt = cur.bit_cnt + 3'h1;
            if (cur.bit_cnt == 3'h7)
            begin
              nxt.done_cnt = cur.done_cnt + 16'h0001;
              nxt.rx_pend = cur.rx_en;
              nxt.state = QSM_BYTE;
            end
          end
        end
        else
          nxt.div = cur.div + 2'h1;
      default:
        nxt.state = QSM_IDLE;
    endcase
    nxt.tx_wr = cur.tx_wr + PTR_W'(tx_push);
    nxt.tx_rd = cur.tx_rd + PTR_W'(tx_pop);
    nxt.tx_cnt = fifo_next(cur.tx_cnt, tx_push, tx_pop);
    nxt.rx_wr = cur.rx_wr + PTR_W'(rx_push);
    nxt.rx_rd = cur.rx_rd + PTR_W'(rx_pop);
    nxt.rx_cnt = fifo_next(cur.rx_cnt, rx_push, rx_pop);
    if (flush)
    begin
      nxt.tx_wr = '0;
      nxt.tx_rd = '0;
      nxt.tx_cnt = '0;
      nxt.rx_wr = '0;
      nxt.rx_rd = '0;
      nxt.rx_cnt = '0;
      nxt.rx_pend = 1'b0;
    end
    // Hardware set wins over a same-cycle software clear
    if (clr_rx_stall && !set_rx_stall)
      nxt.rx_stall = 1'b0;
    if (clr_tx_stall && !set_tx_stall)
      nxt.tx_stall = 1'b0;
    nxt.rx_req = (cur.rx_req && !clr_rx_req) || (cur.rx_cnt >= CNT_W'(cur.rx_trig));
    nxt.tx_req = (cur.tx_req && !clr_tx_req) || (cur.tx_cnt <= CNT_W'(cur.tx_trig));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur <= '0;
      cur.cs_n <= CS_IDLE;
      cur.pin <= PIN_RST;
      cur.state <= QSM_IDLE;
    end
    else
      cur <= nxt;
  end

  assign tx_if.we = tx_push;
  assign tx_if.waddr = cur.tx_wr;
  assign tx_if.wdata = cur.w_data[7:0];
  assign tx_if.raddr = nxt.tx_rd;
  assign rx_if.we = rx_push;
  assign rx_if.waddr = cur.rx_wr;
  assign rx_if.wdata = cur.rxsh;
  assign rx_if.raddr = nxt.rx_rd;

  qsm_fifo_mem u_tx_mem (.aclk(aclk), .aresetn(aresetn), .port(tx_if));
  qsm_fifo_mem u_rx_mem (.aclk(aclk), .aresetn(aresetn), .port(rx_if));

  assign s_axi_awready = !cur.aw_got && !cur.bvalid;
  assign s_axi_wready = !cur.w_got && !cur.bvalid;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rresp = cur.rresp;
  assign s_axi_rdata = cur.rdata;
  assign spi_sclk = cur.sclk;
  assign spi_cs_n = cur.cs_n;
  assign spi_mosi = cur.mosi;
  assign spi_hold = cur.pin[PIN_HOLD_VAL];
  assign spi_hold_oe_n = !cur.pin[PIN_HOLD_EN];
  assign spi_wp = cur.pin[PIN_WP_VAL];
  assign spi_wp_oe_n = !cur.pin[PIN_WP_EN];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence pin_write_s;
    wr_do && cur.aw_addr == OFF_PIN && cur.w_strb[0];
  endsequence
  sequence byte_boundary_s;
    cur.state == QSM_BYTE && !cur.rx_pend;
  endsequence

  flush_empties_a: assert property (flush |=> cur.tx_cnt == '0 && status_word[13]
    && status_word[9]) else $error("flush left data in a FIFO");
  halt_stop_a: assert property (byte_boundary_s and cur.halt_pend |=>
    cur.state == QSM_IDLE && spi_cs_n ##1 spi_cs_n) else $error("halt did not stop");
  launch_go_a: assert property (launch && cur.state == QSM_IDLE |=>
    status_word[16] && cur.done_cnt == 16'h0000) else $error("launch ignored");
  hold_drive_a: assert property (pin_write_s |=> spi_hold_oe_n == !$past(cur.w_data[3])
    && spi_hold == $past(cur.w_data[2])) else $error("hold pin wrong");
  wp_drive_a: assert property (pin_write_s |=> spi_wp_oe_n == !$past(cur.w_data[1])
    && spi_wp == $past(cur.w_data[0])) else $error("write protect pin wrong");
  rx_stall_a: assert property (cur.state == QSM_BYTE && cur.rx_pend && fifo_full(cur.rx_cnt)
    && !flush && !rx_pop |=> cur.rx_stall && cur.rx_pend && !spi_sclk) else $error("rx stall");
  rx_req_a: assert property (cur.rx_cnt >= CNT_W'(cur.rx_trig) |=> cur.rx_req)
    else $error("rx request flag missing");
  tx_stall_a: assert property (byte_boundary_s and (cur.tx_en && cur.tx_cnt == '0
    && !cur.halt_pend && cur.xfer_len == '0) |=> cur.tx_stall && cur.state == QSM_BYTE)
    else $error("tx stall");
  tx_req_a: assert property (cur.tx_cnt <= CNT_W'(cur.tx_trig) |=> cur.tx_req)
    else $error("tx request flag missing");
  close_end_a: assert property (byte_boundary_s and (!cur.halt_pend && cur.close_en
    && cur.xfer_len != '0 && cur.done_cnt == cur.xfer_len) |=> spi_cs_n
    && !status_word[16]) else $error("close did not release select");
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import qsm_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m; logic [1:0] r;} qsm_note_s;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_hold, spi_hold_oe_n, spi_wp, spi_wp_oe_n;
  int failures = 0;
  int n_compared = 0;
  int i, k;
  logic [3:0] p;
  logic [7:0] b0, b1;
  logic [1:0] bq[$];
  qsm_note_s rq[$];
  qsm_note_s note;

  qsm_quad_serial_master i_qsm_quad_serial_master (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .spi_sclk, .spi_cs_n, .spi_mosi,
    .spi_miso, .spi_hold, .spi_hold_oe_n, .spi_wp, .spi_wp_oe_n);
  qsm_flash i_qsm_flash (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic lost();
    failures++;
    $display("mismatch at %0t: wait ran out", $time);
    tally_and_finish();
  endtask

  // Handshakes judged at the falling edge, where readies have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ha, hw, hb;
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 100) lost();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    int n;
    logic ha, hr;
    @(posedge aclk);
    rq.push_back('{e & m, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 100) lost();
  endtask

  task automatic wait_cs(input logic lvl);
    int n;
    for (n = 0; n < 2000 && spi_cs_n !== lvl; n++) @(posedge aclk);
    if (n == 2000) lost();
  endtask

  task automatic wait_got(input int cnt);
    int n;
    for (n = 0; n < 3000 && i_qsm_flash.got.size() < cnt; n++) @(posedge aclk);
    if (n == 3000) lost();
  endtask

  always @(negedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      chk(32'(s_axi_bresp), 32'(bq.pop_front()));
    if (s_axi_rvalid && s_axi_rready)
    begin
      note = rq.pop_front();
      chk(s_axi_rdata & note.m, note.e);
      chk(32'(s_axi_rresp), 32'(note.r));
    end
  end

  initial
  begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    void'($urandom(32'hf6df));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_STAT, 32'h0000_6600, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_PIN, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
    for (i = 0; i < 16; i++)
    begin
      p = 4'(i);
      wr(OFF_PIN, {28'($urandom()), p}, RESP_OKAY);
      rd(OFF_PIN, {28'h0, p}, 32'hFFFF_FFFF, RESP_OKAY);
      chk({spi_hold_oe_n, spi_hold & !spi_hold_oe_n}, {!p[3], p[3] & p[2]});
      chk({spi_wp_oe_n, spi_wp & !spi_wp_oe_n}, {!p[1], p[1] & p[0]});
    end
    wr(8'h04, 32'h1, RESP_SLVERR);
    rd(8'h30, 32'h0, 32'h0, RESP_SLVERR);
    chk(32'(spi_cs_n), 32'h1);
    wr(OFF_CFG, 32'h0000_0052, RESP_OKAY);
    rd(OFF_STAT, 32'h0500_0000, 32'h0F00_0000, RESP_OKAY);
    // Single-line mode only, so both directions may be on
    b0 = 8'($urandom());
    b1 = 8'($urandom());
    wr(OFF_TRIG, 32'h0000_0200, RESP_OKAY);
    wr(OFF_DATA, {24'h0, b0}, RESP_OKAY);
    wr(OFF_DATA, {24'h0, b1}, RESP_OKAY);
    wr(OFF_STAT, 32'h0000_4400, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_2000, 32'h0000_FF00, RESP_OKAY);
    wr(OFF_CFG, 32'h0002_000D, RESP_OKAY);
    wr(OFF_CMD, 32'h1, RESP_OKAY);
    rd(OFF_STAT, 32'h0001_0000, 32'h0001_0000, RESP_OKAY);
    rd(OFF_CMD, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
    wait_cs(1'b1);
    rd(OFF_STAT, 32'h0000_4600, 32'h0001_FF00, RESP_OKAY);
    chk(32'(i_qsm_flash.got[0]), 32'(b0));
    chk(32'(i_qsm_flash.got[1]), 32'(b1));
    rd(OFF_DATA, 32'(i_qsm_flash.sent[0]), 32'hFF, RESP_OKAY);
    rd(OFF_DATA, 32'(i_qsm_flash.sent[1]), 32'hFF, RESP_OKAY);
    chk(32'(spi_sclk), 32'h0);
    // Halt goes in its own write, never beside launch
    wr(OFF_CFG, 32'h0, RESP_OKAY);
    wr(OFF_CMD, 32'h1, RESP_OKAY);
    repeat (60 + $urandom_range(80)) @(posedge aclk);
    wr(OFF_CMD, 32'h2, RESP_OKAY);
    wait_cs(1'b1);
    chk(32'(i_qsm_flash.nbit % 8), 32'h0);
    rd(OFF_STAT, 32'h0, 32'h0001_0000, RESP_OKAY);
    wr(OFF_CFG, 32'h0001_0004, RESP_OKAY);
    wr(OFF_CMD, 32'h1, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(OFF_STAT, 32'h0001_0800, 32'h0001_0800, RESP_OKAY);
    k = i_qsm_flash.got.size();
    b0 = 8'($urandom());
    wr(OFF_DATA, {24'h0, b0}, RESP_OKAY);
    wait_got(k + 1);
    chk(32'(i_qsm_flash.got[k]), 32'(b0));
    wr(OFF_STAT, 32'h0000_0800, RESP_OKAY);
    rd(OFF_STAT, 32'h0, 32'h0000_0800, RESP_OKAY);
    wr(OFF_CMD, 32'h2, RESP_OKAY);
    wait_cs(1'b1);
    wr(OFF_CFG, 32'h000A_0008, RESP_OKAY);
    k = i_qsm_flash.got.size();
    wr(OFF_CMD, 32'h1, RESP_OKAY);
    wait_got(k + 9);
    // About one byte time, so the ninth byte meets a full FIFO
    repeat (40) @(posedge aclk);
    rd(OFF_STAT, 32'h0001_D000, 32'h0001_F000, RESP_OKAY);
    repeat (FIFO_DEPTH) wr(OFF_DATA, {24'h0, 8'($urandom())}, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_0100, 32'h0000_0300, RESP_OKAY);
    wr(OFF_CMD, 32'h4, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_2200, 32'h0000_3300, RESP_OKAY);
    rd(OFF_DATA, 32'h0, 32'hFF, RESP_OKAY);
    wr(OFF_STAT, 32'h0000_8000, RESP_OKAY);
    rd(OFF_STAT, 32'h0, 32'h0000_8000, RESP_OKAY);
    wr(OFF_CMD, 32'h2, RESP_OKAY);
    wait_cs(1'b1);
    repeat (4) @(posedge aclk);
    tally_and_finish();
  end
endmodule
